// ### arf_pkg.sv
// Package for the ADC ready-flag and comparator select register bank.
// Assumes a single 250 MHz clock domain and a word-aligned register port.
package arf_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W = 16;
  localparam int unsigned NUM_IN = 54;
  localparam int unsigned NUM_CMP = 4;
  localparam int unsigned CMP_IN_MAX = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_RDY_LOW = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_RDY_HIGH = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CMP_CTRL = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CMP_MASK = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_CMP_LIM = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_DATA = 12'h100;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned LIM_HI_LSB = 16;
  localparam int unsigned LIM_LO_LSB = 0;
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_OVERRUN = 1;
  localparam int unsigned IRQ_W = 2;

  // Implemented ready flags by input number; bits 32..63 map to the high word
  localparam logic [63:0] IMPL_FULL = 64'h003F_E3FE_0FFF_FFFF;
  // Inputs 20-23 and 33-47 absent on the reduced-pin variant
  localparam logic [63:0] IMPL_REDUCED = 64'h003F_0000_0F0F_FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_FLAGS = 64'h0000_0000_0000_0000;
  localparam logic [RES_W-1:0] RST_RES = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [5:0] chan;
    logic [RES_W-1:0] data;
  } arf_result_t;

  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [RES_W-1:0] data;
  } arf_cmp_feed_t;

  typedef struct packed {
    logic [RES_W-1:0] high;
    logic [RES_W-1:0] low;
  } arf_limits_t;

endpackage

// ### arf_top.sv
// ADC data registers, ready flags, comparator input masks and limits.
// Assumes results arrive synchronous to mclk, one per cycle at most.
module arf_top #(
  parameter bit REDUCED_PIN = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [arf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [arf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [arf_pkg::DATA_W-1:0] reg_rdata,
  input wire arf_pkg::arf_result_t result_in,
  output arf_pkg::arf_cmp_feed_t cmp_feed [arf_pkg::NUM_CMP],
  output arf_pkg::arf_limits_t cmp_limits [arf_pkg::NUM_CMP],
  output logic [arf_pkg::NUM_CMP-1:0] comparator_enable,
  output logic irq
);

  localparam logic [63:0] IMPL = REDUCED_PIN ? arf_pkg::IMPL_REDUCED : arf_pkg::IMPL_FULL;
  localparam logic [arf_pkg::DATA_W-1:0] MASK_IMPL = IMPL[31:0];

  // The register map has room for 64 inputs, four comparators and 16-bit results
  if (arf_pkg::NUM_IN > 64) begin : g_bad_inputs
    $error("Input count exceeds the two ready words");
  end
  if (arf_pkg::NUM_CMP != 4) begin : g_bad_cmps
    $error("Comparator count must match the enable field and address map");
  end
  if (arf_pkg::CMP_IN_MAX > 32) begin : g_bad_cmp_range
    $error("Comparator inputs must fit one mask word");
  end
  if (arf_pkg::RES_W != 16) begin : g_bad_res
    $error("Result width must fill the low half of a data word");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [63:0] rdy_q;
  logic [63:0] rdy_d;
  logic [arf_pkg::RES_W-1:0] data_mem_q [arf_pkg::NUM_IN];
  logic [arf_pkg::DATA_W-1:0] mask_q [arf_pkg::NUM_CMP];
  logic [arf_pkg::NUM_CMP-1:0] cmp_en_q;
  logic [arf_pkg::IRQ_W-1:0] irq_stat_q;
  logic [arf_pkg::IRQ_W-1:0] irq_mask_q;
  logic [arf_pkg::IRQ_W-1:0] irq_stat_d;
  logic [arf_pkg::IRQ_W-1:0] irq_mask_d;
  logic [arf_pkg::DATA_W-1:0] rdata_d;
  logic irq_q;

  logic res_ok;
  logic data_hit;
  logic [5:0] data_idx;
  logic data_rd;
  logic cmp_ok;

  // Results for inputs that do not exist on this variant are dropped
  assign res_ok = result_in.valid && (result_in.chan < 6'(arf_pkg::NUM_IN)) && IMPL[result_in.chan];
  assign data_hit = (reg_addr[arf_pkg::ADDR_W-1:8] == arf_pkg::OFS_DATA[arf_pkg::ADDR_W-1:8]);
  assign data_idx = reg_addr[7:2];
  // Data words of absent inputs read zero rather than never-written storage
  assign data_rd = reg_rd && data_hit && (data_idx < 6'(arf_pkg::NUM_IN)) && IMPL[data_idx];
  assign cmp_ok = res_ok && (result_in.chan < 6'(arf_pkg::CMP_IN_MAX));

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  always_ff @(posedge mclk) begin
    if (res_ok) begin
      data_mem_q[result_in.chan] <= result_in.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready flags: a landing result beats a read clear in the same cycle
  always_comb begin
    rdy_d = rdy_q;
    if (data_rd) begin
      rdy_d[data_idx] = 1'b0;
    end
    if (res_ok) begin
      rdy_d[result_in.chan] = 1'b1;
    end
    rdy_d = rdy_d & IMPL;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdy_q <= arf_pkg::RST_FLAGS;
    end else begin
      rdy_q <= rdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator enable, masks and limits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp_en_q <= '0;
    end else if (reg_wr && reg_addr == arf_pkg::OFS_CMP_CTRL) begin
      cmp_en_q <= reg_wdata[arf_pkg::NUM_CMP-1:0];
    end
  end

  for (genvar c = 0; c < arf_pkg::NUM_CMP; c++) begin : g_cmp
    localparam logic [arf_pkg::ADDR_W-1:0] MASK_ADDR = arf_pkg::OFS_CMP_MASK + arf_pkg::ADDR_W'(4 * c);
    localparam logic [arf_pkg::ADDR_W-1:0] LIM_ADDR = arf_pkg::OFS_CMP_LIM + arf_pkg::ADDR_W'(4 * c);

    // Mask is written even while enabled; software is trusted to avoid it
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mask_q[c] <= arf_pkg::RST_WORD;
      end else if (reg_wr && reg_addr == MASK_ADDR) begin
        mask_q[c] <= reg_wdata & MASK_IMPL;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cmp_limits[c] <= '0;
      end else if (reg_wr && reg_addr == LIM_ADDR) begin
        cmp_limits[c].high <= reg_wdata[arf_pkg::LIM_HI_LSB +: arf_pkg::RES_W];
        cmp_limits[c].low <= reg_wdata[arf_pkg::LIM_LO_LSB +: arf_pkg::RES_W];
      end
    end

    // Feed is registered so the comparator sees a clean one-cycle strobe
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cmp_feed[c] <= '0;
      end else begin
        cmp_feed[c].valid <= cmp_ok && cmp_en_q[c] && mask_q[c][result_in.chan[4:0]];
        cmp_feed[c].chan <= result_in.chan[4:0];
        cmp_feed[c].data <= result_in.data;
      end
    end
  end

  assign comparator_enable = cmp_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: ready event and overrun of an unread result
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (reg_wr && reg_addr == arf_pkg::OFS_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[arf_pkg::IRQ_W-1:0];
    end
    if (res_ok) begin
      irq_stat_d[arf_pkg::IRQ_READY] = 1'b1;
    end
    if (res_ok && rdy_q[result_in.chan] &&
        !(data_rd && data_idx == result_in.chan)) begin
      irq_stat_d[arf_pkg::IRQ_OVERRUN] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

  // Next mask feeds the irq flop so that irq never lags a mask write
  always_comb begin
    irq_mask_d = irq_mask_q;
    if (reg_wr && reg_addr == arf_pkg::OFS_IRQ_MASK) begin
      irq_mask_d = reg_wdata[arf_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= '0;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: unmapped addresses read zero
  always_comb begin
    rdata_d = arf_pkg::RST_WORD;
    if (data_rd) begin
      rdata_d = {16'h0000, data_mem_q[data_idx]};
    end else begin
      case (reg_addr)
        arf_pkg::OFS_RDY_LOW: rdata_d = rdy_q[31:0];
        arf_pkg::OFS_RDY_HIGH: rdata_d = rdy_q[63:32];
        arf_pkg::OFS_CMP_CTRL: rdata_d = {28'h0000000, cmp_en_q};
        arf_pkg::OFS_IRQ_STAT: rdata_d = {30'h00000000, irq_stat_q};
        arf_pkg::OFS_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
        default: begin
          for (int c = 0; c < arf_pkg::NUM_CMP; c++) begin
            if (reg_addr == arf_pkg::OFS_CMP_MASK + arf_pkg::ADDR_W'(4 * c)) begin
              rdata_d = mask_q[c];
            end
            if (reg_addr == arf_pkg::OFS_CMP_LIM + arf_pkg::ADDR_W'(4 * c)) begin
              rdata_d = {cmp_limits[c].high, cmp_limits[c].low};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= arf_pkg::RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= arf_pkg::RST_WORD;
    end
  end

endmodule

// ### arf_top_sva.sv
// Checker for the ready-flag and comparator select bank.
// Bound to arf_top; sees its ports only, one clock domain.
module arf_top_sva #(
  parameter bit REDUCED_PIN = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire arf_pkg::arf_result_t result_in,
  input wire arf_pkg::arf_cmp_feed_t cmp_feed [arf_pkg::NUM_CMP],
  input wire arf_pkg::arf_limits_t cmp_limits [arf_pkg::NUM_CMP],
  input wire logic [3:0] comparator_enable,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_LOW_TOP: assert property ($past(reg_rd) && $past(reg_addr) == 12'h000 |-> reg_rdata[31:28] == 4'h0)
    else $error("ready low top bits set");
  AST_HIGH_GAPS: assert property ($past(reg_rd) && $past(reg_addr) == 12'h004
    |-> reg_rdata[31:22] == 10'h000 && reg_rdata[12:10] == 3'h0 && !reg_rdata[0])
    else $error("ready high gap bits set");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_LIMITS: assert property ($past(reg_wr) && $past(reg_addr) == 12'h030 |-> cmp_limits[0] == $past(reg_wdata))
    else $error("limit fields misplaced");
  AST_RESET_ZERO: assert property ($past(rst) |-> comparator_enable == 4'h0 && !irq)
    else $error("not zero after reset");
  for (genvar c = 0; c < 4; c++) begin : g_cmp
    AST_FEED_SRC: assert property (cmp_feed[c].valid |-> $past(result_in.valid) && $past(result_in.chan) < 6'h20)
      else $error("comparator fed from wrong input");
    AST_FEED_EN: assert property (cmp_feed[c].valid |-> $past(comparator_enable[c])
      && cmp_feed[c].data == $past(result_in.data) && cmp_feed[c].chan == $past(result_in.chan[4:0]))
      else $error("feed without enable or wrong data");
    AST_FEED_REDUCED: assert property (cmp_feed[c].valid && REDUCED_PIN |-> !(cmp_feed[c].chan inside {[20:23]}))
      else $error("absent input fed comparator");
  end
endmodule
bind arf_top arf_top_sva #(.REDUCED_PIN(REDUCED_PIN)) arf_top_sva_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_in(result_in),
  .cmp_feed(cmp_feed), .cmp_limits(cmp_limits), .comparator_enable(comparator_enable), .irq(irq));

// ### arf_conv_model.sv
// Conversion-core model: one result pulse per request.
// Assumes go is raised for one cycle right after a rising edge.
module arf_conv_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic [5:0] ch,
  input wire logic [15:0] dat,
  output arf_pkg::arf_result_t res
);
  // Idle fields toggle so a stale value is never mistaken for a result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      res <= '0;
    end else if (go) begin
      res <= '{valid: 1'b1, chan: ch, data: dat};
    end else begin
      res <= '{valid: 1'b0, chan: ~res.chan, data: ~res.data};
    end
  end
endmodule

// ### arf_top_test.sv
// Testbench for the ready-flag and comparator select bank.
// Drives the register port and a core model on one 250 MHz clock.
module arf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, reg_wr, reg_rd, go, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [5:0] ch;
  logic [15:0] dat;
  logic [3:0] comparator_enable;
  arf_pkg::arf_result_t result_in;
  arf_pkg::arf_cmp_feed_t cmp_feed [arf_pkg::NUM_CMP];
  arf_pkg::arf_limits_t cmp_limits [arf_pkg::NUM_CMP];
  // Reduced-pin instance shares all stimulus with the full one
  logic [31:0] rdata_r;
  logic irq_r;
  logic [3:0] en_r;
  logic [15:0] fd0 = '0;
  arf_pkg::arf_cmp_feed_t feed_r [arf_pkg::NUM_CMP];
  arf_pkg::arf_limits_t lim_r [arf_pkg::NUM_CMP];
  int error_cnt = 0, comparisons = 0, cyc = 0, fc0 = 0, fc1 = 0, fr0 = 0;
  arf_top #(.REDUCED_PIN(1'b0)) arf_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_in(result_in), .cmp_feed(cmp_feed),
    .cmp_limits(cmp_limits), .comparator_enable(comparator_enable), .irq(irq));
  arf_top #(.REDUCED_PIN(1'b1)) arf_top_reduced_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_r), .result_in(result_in),
    .cmp_feed(feed_r), .cmp_limits(lim_r), .comparator_enable(en_r), .irq(irq_r));
  arf_conv_model arf_conv_model_i (.mclk(mclk), .rst(rst), .go(go), .ch(ch), .dat(dat), .res(result_in));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    fc0 += int'(cmp_feed[0].valid === 1'b1);
    fc1 += int'(cmp_feed[1].valid === 1'b1);
    fr0 += int'(feed_r[0].valid === 1'b1);
    if (cmp_feed[0].valid === 1'b1) begin
      fd0 = cmp_feed[0].data;
    end
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task send(input logic [5:0] c);
    @(posedge mclk);
    go <= 1'b1;
    ch <= c;
    dat <= 16'hA500 | 16'(c);
    @(posedge mclk);
    go <= 1'b0;
  endtask
  ////////////////////////////////////////
  task t_reset;
    logic [11:0] a [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h020, 12'h030, 12'h040};
    foreach (a[i]) rdc(a[i], 32'h0, "reset value");
  endtask
  task t_ready;
    logic [5:0] c [7] = '{6'h05, 6'h1B, 6'h1C, 6'h21, 6'h2A, 6'h35, 6'h3C};
    foreach (c[i]) send(c[i]);
    rdc(12'h000, 32'h0800_0020, "ready low");
    rdc(12'h004, 32'h0020_0002, "ready high");
    chk("ready high reduced", 32'h0020_0000, rdata_r);
    wr(12'h000, 32'hFFFF_FFFF);
    rdc(12'h000, 32'h0800_0020, "ready low after write");
    rdc(12'h114, 32'h0000_A505, "data 5");
    rdc(12'h000, 32'h0800_0000, "ready low after data read");
  endtask
  task t_compare;
    wr(12'h020, 32'hFFFF_FFFF);
    rdc(12'h020, 32'h0FFF_FFFF, "mask 0");
    chk("mask 0 reduced", 32'h0F0F_FFFF, rdata_r);
    wr(12'h024, 32'hFFFF_FFFF);
    wr(12'h008, 32'h1);
    #1;
    chk("enables", 32'h1, 32'(comparator_enable));
    chk("enables reduced", 32'h1, 32'(en_r));
    send(6'h07);
    send(6'h1E);
    send(6'h14);
    send(6'h28);
    repeat (3) @(posedge mclk);
    #1;
    chk("feeds 0", 32'h2, 32'(fc0));
    chk("feeds 1", 32'h0, 32'(fc1));
    chk("feed data", 32'h0000_A514, 32'(fd0));
    chk("feeds reduced", 32'h1, 32'(fr0));
  endtask
  task t_limits;
    wr(12'h030, 32'hABCD_1234);
    #1;
    chk("limit high", 32'h0000_ABCD, 32'(cmp_limits[0].high));
    chk("limit low", 32'h0000_1234, 32'(cmp_limits[0].low));
    chk("limit reduced", 32'hABCD_1234, 32'(lim_r[0]));
    rdc(12'h030, 32'hABCD_1234, "limits 0");
  endtask
  task t_irq;
    chk("irq masked", 32'h0, 32'(irq));
    wr(12'h010, 32'h1);
    @(posedge mclk);
    #1;
    chk("irq raised", 32'h1, 32'(irq));
    chk("irq reduced", 32'h1, 32'(irq_r));
    // Second result on a still-flagged input also marks overrun
    send(6'h07);
    rdc(12'h00C, 32'h3, "irq status");
    wr(12'h00C, 32'h3);
    @(posedge mclk);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    chk("irq reduced cleared", 32'h0, 32'(irq_r));
  endtask
  // Reset in mid-run, with ready flags, masks 0 and 1 and limits 0 non-zero beforehand
  task t_rereset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc(12'h000, 32'h0, "ready low after reset");
    rdc(12'h020, 32'h0, "mask 0 after reset");
    rdc(12'h030, 32'h0, "limits after reset");
    chk("enables after reset", 32'h0, 32'(comparator_enable));
  endtask
  task stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    ch = '0;
    dat = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_ready();
    t_compare();
    t_limits();
    t_irq();
    t_rereset();
    stop_test();
  end
endmodule
